// ===== hdl/esf_pkg.sv
// package: register map, field positions and shared types for event flags
package esf_pkg;

    // =========================================================
    // register offsets
    localparam logic [5:0] ESF_OFS_STATUS   = 6'h02;
    localparam logic [5:0] ESF_OFS_CHECKSUM = 6'h03;

    // =========================================================
    // field positions in the event status register
    localparam int ESF_BIT_POWER_ON  = 0;
    localparam int ESF_BIT_SUPPLY_LO = 7;
    localparam int ESF_BIT_CK_DONE   = 8;
    localparam int ESF_BIT_FAC_ERR   = 13;

    // =========================================================
    // reset values and checksum polynomial
    localparam logic [23:0] ESF_STATUS_RST   = 24'h00_0001;
    localparam logic [23:0] ESF_CHECKSUM_RST = 24'h00_FFFF;
    localparam logic [15:0] ESF_CK_SEED      = 16'hFFFF;
    localparam logic [15:0] ESF_CK_POLY      = 16'h1021;

    // =========================================================
    // checksum engine states and shared carriers
    typedef enum logic [1:0] {
        ESF_CK_IDLE = 2'b00,
        ESF_CK_RUN  = 2'b01,
        ESF_CK_DONE = 2'b10
    } esf_ck_state_t;

    typedef struct packed {
        logic fac_err;
        logic supply_lo;
        logic ck_done;
        logic power_on;
    } esf_events_t;

    typedef struct packed {
        logic       rd_en;
        logic [5:0] addr;
    } esf_rd_req_t;

endpackage : esf_pkg

// ===== hdl/esf_checksum.sv
// serial checksum engine over a stream of 24-bit register words
module esf_checksum (
    // clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst_n,
    // control
    input  wire logic        i_start,
    input  wire logic [23:0] i_word,
    input  wire logic        i_word_valid,
    input  wire logic        i_word_last,
    // result
    output logic             o_busy,
    output logic             o_done,
    output logic [15:0]      o_result
);

    // =========================================================
    // state
    esf_pkg::esf_ck_state_t state_r;
    logic [15:0]            crc_r;
    logic [15:0]            crc_nxt;

    always_comb begin
        crc_nxt = crc_r;
        for (int b = 23; b >= 0; b--) begin
            if (crc_nxt[15] ^ i_word[b]) begin
                crc_nxt = {crc_nxt[14:0], 1'b0} ^ esf_pkg::ESF_CK_POLY;
            end else begin
                crc_nxt = {crc_nxt[14:0], 1'b0};
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r <= esf_pkg::ESF_CK_IDLE;
            crc_r   <= esf_pkg::ESF_CK_SEED;
        end else begin
            case (state_r)
                esf_pkg::ESF_CK_IDLE: begin
                    if (i_start) begin
                        state_r <= esf_pkg::ESF_CK_RUN;
                        crc_r   <= esf_pkg::ESF_CK_SEED;
                    end
                end
                esf_pkg::ESF_CK_RUN: begin
                    if (i_word_valid) begin
                        crc_r <= crc_nxt;
                        if (i_word_last) begin
                            state_r <= esf_pkg::ESF_CK_DONE;
                        end
                    end
                end
                esf_pkg::ESF_CK_DONE: begin
                    state_r <= esf_pkg::ESF_CK_IDLE;
                end
                default: begin
                    state_r <= esf_pkg::ESF_CK_IDLE;
                end
            endcase
        end
    end

    assign o_busy   = (state_r == esf_pkg::ESF_CK_RUN);
    assign o_done   = (state_r == esf_pkg::ESF_CK_DONE);
    assign o_result = crc_r;

endmodule // esf_checksum

// ===== hdl/esf_event_flags.sv
// event status flags, checksum trigger/result and event output pin
// What this block does
// RULE1: factory-check error sets status bit 13 when factory load fails.
// RULE2: after factory load a self-check verdict is taken from the loader.
// RULE3: failed self-check sets factory-check error with the power-on flag.
// RULE4: host should issue software reset on factory-check error; advisory.
// RULE5: factory-check error reads zero after good load or status read.
// RULE6: checksum-done bit 8 sets once a triggered checksum finishes.
// RULE7: checksum-done reads zero while running, unstarted, or after read; here a new start leaves an unread done flag set.
// RULE8: finished checksum result is readable at offset 3h.
// RULE9: host triggers checksum over programmed registers; device computes it.
// RULE10: supply-low bit 7 sets when under-voltage begins.
// RULE11: supply-low also sets when under-voltage goes away.
// RULE12: supply-low reads zero if no change since last status read.
// RULE13: status register read clears all flags to default value.
// RULE14: event pin released at chip-select rising edge ending status read.
// RULE15: flags hold set until a status read; repeats keep them set.
module esf_event_flags (
    // clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_resetn,
    // register read port from the serial front end
    input  wire logic        i_rd_en,
    input  wire logic [5:0]  i_rd_addr,
    input  wire logic        i_cs_rise,
    output logic [23:0]      o_rd_data,
    // factory settings loader
    input  wire logic        i_fac_load_done,
    input  wire logic        i_fac_check_ok,
    // supply monitor
    input  wire logic        i_supply_low,
    // checksum trigger and register word stream
    input  wire logic        i_ck_start,
    input  wire logic [23:0] i_ck_word,
    input  wire logic        i_ck_word_valid,
    input  wire logic        i_ck_word_last,
    output logic             o_ck_busy,
    // event output pin, open drain, and status word
    output logic             o_event_n_out,
    output logic             o_event_n_oe,
    output logic [23:0]      o_status
);

    // =========================================================
    // reset release
    logic rst_meta_r;
    logic rst_n_r;

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_meta_r <= 1'b0;
            rst_n_r    <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r    <= rst_meta_r;
        end
    end

    // =========================================================
    // checksum engine
    logic        ck_done;
    logic [15:0] ck_result;

    esf_checksum u_checksum (
        .i_clk_sys    (i_clk_sys),
        .i_rst_n      (rst_n_r),
        .i_start      (i_ck_start),           // RULE9
        .i_word       (i_ck_word),
        .i_word_valid (i_ck_word_valid),
        .i_word_last  (i_ck_word_last),
        .o_busy       (o_ck_busy),
        .o_done       (ck_done),
        .o_result     (ck_result)
    );

    // =========================================================
    // event detection
    logic supply_low_d_r;
    logic fac_seen_r;
    esf_pkg::esf_events_t ev;
    esf_pkg::esf_events_t flags_r;
    logic status_rd;
    logic clr_pend_r;

    always_ff @(posedge i_clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            supply_low_d_r <= 1'b0;
            fac_seen_r     <= 1'b0;
        end else begin
            supply_low_d_r <= i_supply_low;
            if (i_fac_load_done) begin
                fac_seen_r <= 1'b1;
            end
        end
    end

    always_comb begin
        // one-shot verdict on the first load completion
        ev.fac_err = i_fac_load_done & ~fac_seen_r & ~i_fac_check_ok; // RULE2
        ev.power_on  = ev.fac_err;                                // RULE3
        ev.supply_lo = i_supply_low ^ supply_low_d_r;    // RULE10 RULE11
        ev.ck_done   = ck_done;                                   // RULE6
    end

    // =========================================================
    // sticky flags; the clear is deferred to the chip-select rise so the
    // value shifted out stays stable, and a same-cycle event wins
    assign status_rd = i_rd_en && (i_rd_addr == esf_pkg::ESF_OFS_STATUS);

    always_ff @(posedge i_clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            clr_pend_r <= 1'b0;
        end else if (i_cs_rise) begin
            clr_pend_r <= 1'b0;
        end else if (status_rd) begin
            clr_pend_r <= 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            flags_r <= esf_pkg::esf_events_t'(4'b0001);
        end else if (i_cs_rise && (clr_pend_r || status_rd)) begin
            flags_r <= ev;  // RULE13 RULE5 RULE7 RULE12
        end else begin
            flags_r <= flags_r | ev;                              // RULE15
        end
    end

    // =========================================================
    // checksum result register, seeded until the first run completes
    logic [23:0] ck_result_r;

    always_ff @(posedge i_clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ck_result_r <= esf_pkg::ESF_CHECKSUM_RST;
        end else if (ck_done) begin
            ck_result_r <= {8'h00, ck_result};                     // RULE8
        end
    end

    // =========================================================
    // status word and read data
    always_comb begin
        o_status = 24'h00_0000;
        o_status[esf_pkg::ESF_BIT_FAC_ERR]   = flags_r.fac_err;   // RULE1
        o_status[esf_pkg::ESF_BIT_CK_DONE]   = flags_r.ck_done;
        o_status[esf_pkg::ESF_BIT_SUPPLY_LO] = flags_r.supply_lo;
        o_status[esf_pkg::ESF_BIT_POWER_ON]  = flags_r.power_on;
    end

    always_ff @(posedge i_clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            o_rd_data <= 24'h00_0000;
        end else if (i_rd_en) begin
            case (i_rd_addr)
                esf_pkg::ESF_OFS_STATUS:   o_rd_data <= o_status;
                esf_pkg::ESF_OFS_CHECKSUM: o_rd_data <= ck_result_r;
                default:                   o_rd_data <= 24'h00_0000;
            endcase
        end
    end

    // =========================================================
    // event pin: pulled low while any flag is set; the flag clear lands
    // on the chip-select rise, so the pin releases on that same edge
    assign o_event_n_out = 1'b0;
    assign o_event_n_oe  = |flags_r;                              // RULE14

endmodule // esf_event_flags

// ===== verif/esf_event_flags_checker.sv
// checker: port assertions for the event flag block
module esf_event_flags_checker (
    // watched ports
    input wire logic        i_clk_sys,
    input wire logic        i_resetn,
    input wire logic        i_rd_en,
    input wire logic [5:0]  i_rd_addr,
    input wire logic        i_cs_rise,
    input wire logic        i_fac_load_done,
    input wire logic [23:0] o_rd_data,
    input wire logic        i_supply_low,
    input wire logic        i_ck_word_valid,
    input wire logic        i_ck_word_last,
    input wire logic        o_event_n_out,
    input wire logic        o_event_n_oe,
    input wire logic [23:0] o_status
);
    timeunit 1ns;
    timeprecision 100ps;
    // mirrors the two-flop reset release inside the block, so no check
    // runs while the block still sits in its delayed reset
    logic [1:0] rel_r;
    logic       st_rd;
    logic       arm_r;
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) rel_r <= 2'b00;
        else rel_r <= {rel_r[0], 1'b1};
    end
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!rel_r[1]);
    // ========
    // clear arms on a status read, fires at the frame end
    assign st_rd = i_rd_en && i_rd_addr == 6'h02;
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) arm_r <= 1'b0;
        else arm_r <= (arm_r || st_rd) && !i_cs_rise;
    end
    status_clear_a: assert property (i_cs_rise && (arm_r || st_rd)
        && !$changed(i_supply_low) && !i_fac_load_done
        |=> (o_status & 24'h00_2081) == 24'h0)
        else $error("flags kept after clear");
    read_value_a: assert property (st_rd |=>
        o_rd_data == $past(o_status)) else $error("bad status read");
    unmapped_zero_a: assert property (i_rd_en && i_rd_addr > 6'h03
        |=> o_rd_data == 24'h0) else $error("unmapped read not zero");
    supply_edge_a: assert property ($changed(i_supply_low)
        |=> o_status[7]) else $error("supply change missed");
    supply_hold_a: assert property (o_status[7] && !i_cs_rise
        |=> $stable(o_status[7])) else $error("supply flag dropped");
    ck_done_a: assert property (i_ck_word_valid && i_ck_word_last
        |-> ##2 o_status[8]) else $error("checksum done late");
    fac_pair_a: assert property ($rose(o_status[13])
        |-> o_status[0]) else $error("factory error alone");
    pin_level_a: assert property (o_event_n_out == 1'b0
        && o_event_n_oe == (o_status != 24'h0)) else $error("event pin");
    cover property (st_rd ##[1:20] i_cs_rise);
    cover property ($changed(i_supply_low));
    cover property ($rose(o_status[8]));
    cover property ($rose(o_status[13]));
endmodule // esf_event_flags_checker

bind esf_event_flags esf_event_flags_checker u_chk (
    .i_clk_sys       (i_clk_sys),
    .i_resetn        (i_resetn),
    .i_rd_en         (i_rd_en),
    .i_rd_addr       (i_rd_addr),
    .i_cs_rise       (i_cs_rise),
    .i_fac_load_done (i_fac_load_done),
    .o_rd_data       (o_rd_data),
    .i_supply_low    (i_supply_low),
    .i_ck_word_valid (i_ck_word_valid),
    .i_ck_word_last  (i_ck_word_last),
    .o_event_n_out   (o_event_n_out),
    .o_event_n_oe    (o_event_n_oe),
    .o_status        (o_status)
);

// ===== verif/esf_host_model.sv
// host model: framed register reads and checksum trigger
module esf_host_model (
    // clock and answer
    input  wire logic        i_clk_sys,
    input  wire logic [23:0] i_rd_data,
    // requests
    output logic             o_rd_en,
    output logic [5:0]       o_rd_addr,
    output logic             o_cs_rise,
    output logic             o_ck_start,
    output logic [23:0]      o_ck_word,
    output logic             o_ck_valid,
    output logic             o_ck_last
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        {o_rd_en, o_cs_rise, o_ck_start, o_ck_valid, o_ck_last} = 5'h00;
        o_rd_addr = 6'h3F;
        o_ck_word = 24'h00_0000;
    end
    // ========
    // one read per frame; idle cycle after so the clear has landed
    task automatic rd(input logic [5:0] a, output logic [23:0] d);
        o_rd_en = 1'b1;
        o_rd_addr = a;
        @(posedge i_clk_sys);
        #1 o_rd_en = 1'b0;
        o_rd_addr = ~a;
        d = i_rd_data;
        o_cs_rise = 1'b1;
        @(posedge i_clk_sys);
        #1 o_cs_rise = 1'b0;
        @(posedge i_clk_sys);
        #1;
    endtask
    task automatic ck(input logic [47:0] w);
        o_ck_start = 1'b1;
        for (int i = 0; i < 2; i++) begin
            @(posedge i_clk_sys);
            #1 o_ck_start = 1'b0;
            {o_ck_valid, o_ck_last} = {1'b1, i == 1};
            o_ck_word = w[47 - 24 * i -: 24];
        end
        @(posedge i_clk_sys);
        #1 {o_ck_valid, o_ck_last} = 2'b00;
        o_ck_word = ~o_ck_word;
    endtask
endmodule // esf_host_model

// ===== verif/esf_event_flags_tb.sv
// testbench: reset values, factory check, supply and checksum flags
module esf_event_flags_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk, rstn, fld, fok, sup, rd, cs, cks, ckv, ckl, busy, eo, oe;
    logic [5:0]  addr;
    logic [23:0] rdd, ckw, st, d;
    logic [47:0] w;
    int          fail_count, comparisons;
    esf_event_flags uut (
        .i_clk_sys(clk), .i_resetn(rstn), .i_rd_en(rd), .i_rd_addr(addr),
        .i_cs_rise(cs), .o_rd_data(rdd), .i_fac_load_done(fld),
        .i_fac_check_ok(fok), .i_supply_low(sup), .i_ck_start(cks),
        .i_ck_word(ckw), .i_ck_word_valid(ckv), .i_ck_word_last(ckl),
        .o_ck_busy(busy), .o_event_n_out(eo), .o_event_n_oe(oe),
        .o_status(st));
    esf_host_model h (
        .i_clk_sys(clk), .i_rd_data(rdd), .o_rd_en(rd), .o_rd_addr(addr),
        .o_cs_rise(cs), .o_ck_start(cks), .o_ck_word(ckw),
        .o_ck_valid(ckv), .o_ck_last(ckl));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // ========
    // compare, verdict and reference checksum
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("compares %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    function automatic logic [15:0] crc(input logic [47:0] m);
        logic [15:0] c;
        c = 16'hFFFF;
        for (int i = 47; i >= 0; i--)
            c = {c[14:0], 1'b0} ^ ((c[15] ^ m[i]) ? 16'h1021 : 16'h0000);
        return c;
    endfunction
    initial begin
        #20us fail_count++;
        $display("watchdog expired");
        close_out();
    end
    initial begin
        fail_count = 0;
        comparisons = 0;
        {rstn, fld, sup, fok} = 4'b0001;
        repeat (20) @(posedge clk);
        #1 rstn = 1'b1;
        repeat (3) @(posedge clk);
        #1 chk(st, 24'h00_0001);
        chk({23'h0, oe}, 24'h00_0001);
        h.rd(6'h03, d);
        chk(d, 24'h00_FFFF);
        h.rd(6'h10, d);
        chk(d, 24'h00_0000);
        h.rd(6'h02, d);
        chk(d, 24'h00_0001);
        chk(st, 24'h00_0000);
        {fld, fok} = 2'b10;
        repeat (2) @(posedge clk);
        #1 chk(st, 24'h00_2001);
        {fld, fok} = 2'b01;
        h.rd(6'h02, d);
        chk(d, 24'h00_2001);
        chk(st, 24'h00_0000);
        chk({23'h0, oe}, 24'h00_0000);
        // host answers the factory error with a reset of the device
        rstn = 1'b0;
        repeat (2) @(posedge clk);
        #1 rstn = 1'b1;
        repeat (3) @(posedge clk);
        #1 chk(st, 24'h00_0001);
        {fld, fok} = 2'b11;
        repeat (2) @(posedge clk);
        #1 chk(st, 24'h00_0001);
        fld = 1'b0;
        h.rd(6'h02, d);
        chk(d, 24'h00_0001);
        chk(st, 24'h00_0000);
        $display("reset and factory test done");
        sup = 1'b1;
        repeat (2) @(posedge clk);
        #1 chk(st, 24'h00_0080);
        h.rd(6'h02, d);
        sup = 1'b0;
        repeat (2) @(posedge clk);
        #1 chk(st, 24'h00_0080);
        h.rd(6'h02, d);
        chk(d, 24'h00_0080);
        chk(st, 24'h00_0000);
        $display("supply test done");
        w = 48'h1234_56AB_CDEF;
        fork
            h.ck(w);
            begin
                @(posedge clk);
                #1 chk({23'h0, busy}, 24'h00_0001);
                chk(st, 24'h00_0000);
            end
        join
        repeat (2) @(posedge clk);
        #1 chk(st, 24'h00_0100);
        h.rd(6'h03, d);
        chk(d, {8'h00, crc(w)});
        h.rd(6'h02, d);
        chk(d, 24'h00_0100);
        chk(st, 24'h00_0000);
        $display("checksum test done");
        close_out();
    end
endmodule // esf_event_flags_tb
